// >>> pkg/eci_map.svh
`ifndef ECI_MAP_SVH
`define ECI_MAP_SVH

// clock and tick timing
`define ECI_CLK_PERIOD_PS      5000
`define ECI_TICK_PERIOD_NS     1000000
// flash timing, in ms, measured inside a one-second frame
`define ECI_FLASH_FRAME_MS     1000
`define ECI_SYS_FLASH_HALF_MS  250
`define ECI_PROT_FLASH_HALF_MS 500
// fixed hold time of a system warning
`define ECI_WARN_HOLD_MIN      1
`define ECI_MS_PER_MIN         60000
// code classes
`define ECI_SERIOUS_MAX        4'h5
`define ECI_SYS_VALID_MASK     16'h6FBE
`define ECI_PROT_VALID_MASK    16'hDA28
// widths
`define ECI_HOLD_W             20
`define ECI_COUNT_W            8

`endif

// >>> pkg/eci_pkg.sv
package eci_pkg;

   // display state, one-hot
   typedef enum logic [2:0] {
      ECI_ST_IDLE    = 3'b001,
      ECI_ST_WARN    = 3'b010,
      ECI_ST_SERIOUS = 3'b100
   } eci_state_e;

   // which code table a reported error belongs to
   typedef enum logic {
      ECI_SET_SYS  = 1'b0,
      ECI_SET_PROT = 1'b1
   } eci_set_e;

   typedef logic [3:0] eci_code_t;

endpackage

// >>> pkg/eci_tick_if.sv
`timescale 1ns/1ps
// ms tick and flash phases shared by the timing modules
interface eci_tick_if;
   logic ms_tick;   // one-cycle pulse every millisecond
   logic sys_on;    // system flash phase, high = lamps lit
   logic prot_on;   // protocol flash phase, high = lamps lit

   modport src (output ms_tick, output sys_on, output prot_on);
   modport snk (input ms_tick, input sys_on, input prot_on);
endinterface

// >>> verilog/eci_tick.sv
`timescale 1ns/1ps
`include "eci_map.svh"
module eci_tick #(
   parameter int CYC_PER_MS = 200000
) (
   input  wire logic clk,        // system clock
   input  wire logic reset_n,    // async reset, active low
   eci_tick_if.src   tk          // tick and flash phases out
);
   import eci_pkg::*;

   localparam int CW = $clog2(CYC_PER_MS + 1);
   localparam int FW = $clog2(`ECI_FLASH_FRAME_MS);

   if (CYC_PER_MS < 1) begin : g_chk
      $error("eci_tick: CYC_PER_MS must be at least 1");
   end

   logic [CW-1:0] cyc_q, cyc_d;
   logic [FW-1:0] frm_q, frm_d;
   logic          tick_q, tick_d;
   logic          sys_q, sys_d;
   logic          prot_q, prot_d;

   // one-second frame of ms; both flash rates derive from it so they stay in step
   always_comb begin
      cyc_d  = cyc_q + CW'(1);
      tick_d = 1'b0;
      frm_d  = frm_q;
      if (cyc_q == CW'(CYC_PER_MS - 1)) begin
         cyc_d  = '0;
         tick_d = 1'b1;
         frm_d  = (frm_q == FW'(`ECI_FLASH_FRAME_MS - 1)) ? '0 : frm_q + FW'(1);
      end
      sys_d  = (frm_q < FW'(`ECI_SYS_FLASH_HALF_MS)) ||
               ((frm_q >= FW'(2 * `ECI_SYS_FLASH_HALF_MS)) &&
                (frm_q < FW'(3 * `ECI_SYS_FLASH_HALF_MS)));   // [RQ7]
      prot_d = (frm_q < FW'(`ECI_PROT_FLASH_HALF_MS));      // [RQ8]
   end

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         cyc_q  <= '0;
         frm_q  <= '0;
         tick_q <= 1'b0;
         sys_q  <= 1'b0;
         prot_q <= 1'b0;
      end else begin
         cyc_q  <= cyc_d;
         frm_q  <= frm_d;
         tick_q <= tick_d;
         sys_q  <= sys_d;
         prot_q <= prot_d;
      end
   end

   assign tk.ms_tick = tick_q;
   assign tk.sys_on  = sys_q;
   assign tk.prot_on = prot_q;

endmodule // eci_tick

// >>> verilog/eci_hold.sv
`timescale 1ns/1ps
`include "eci_map.svh"
module eci_hold (
   input  wire logic                   clk,       // system clock
   input  wire logic                   reset_n,   // async reset, active low
   eci_tick_if.snk                     tk,        // ms tick in
   input  wire logic                   load,      // restart the hold time
   input  wire logic [`ECI_HOLD_W-1:0] load_ms,   // hold time in ms
   output logic                        expired    // one-cycle pulse at end of hold
);
   import eci_pkg::*;

   logic [`ECI_HOLD_W-1:0] cnt_q, cnt_d;
   logic                   exp_q, exp_d;

   // counts whole ms ticks; a zero hold is served as one ms so it still ends
   always_comb begin
      cnt_d = cnt_q;
      exp_d = 1'b0;
      if (load) begin
         cnt_d = (load_ms == '0) ? `ECI_HOLD_W'(1) : load_ms;
      end else if (tk.ms_tick && (cnt_q != '0)) begin
         cnt_d = cnt_q - `ECI_HOLD_W'(1);
         exp_d = (cnt_q == `ECI_HOLD_W'(1));
      end
   end

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         cnt_q <= '0;
         exp_q <= 1'b0;
      end else begin
         cnt_q <= cnt_d;
         exp_q <= exp_d;
      end
   end

   assign expired = exp_q;

endmodule // eci_hold

// >>> verilog/eci_top.sv
// Summary of operation
// [RQ1] on any accepted error, status lamp goes red and code shows on code lamps
// [RQ2] codes 1 to 5 are serious and stay until power is cycled
// [RQ3] system warnings 7 to 14 show for one minute, then clear alone
// [RQ4] in configuration mode the code pattern carries no error meaning
// [RQ5] system errors: 1 hw, 2 store, 3 memory, 4 network hw, 5 script
// [RQ6] system warnings 7,8,9,10,11,13,14; codes 0,6,12,15 are reserved
// [RQ7] system errors flash the code lamps twice per second
// [RQ8] protocol errors flash the code lamps once per second
// [RQ9] protocol codes 3,5,9,11,12,14,15 are defined, others ignored
// [RQ10] protocol warnings are held for the configurable warning time
// [RQ11] code is meaningful only while lamps flash and status lamp is red
// [RQ12] with no error shown, lamps follow the script values
// [RQ13] a serious error overrides a pending warning until power cycle
`timescale 1ns/1ps
`include "eci_map.svh"
module eci_top #(
   parameter int CYC_PER_MS = (`ECI_TICK_PERIOD_NS * 1000) / `ECI_CLK_PERIOD_PS
) (
   input  wire logic                   CLK_SYS,          // 200 MHz system clock
   input  wire logic                   RESET_N,          // power-on reset, active low
   input  wire logic                   ERR_VALID,        // pulse: an error is reported
   input  wire eci_pkg::eci_set_e      ERR_SET,          // table of the reported code
   input  wire eci_pkg::eci_code_t     ERR_CODE,         // reported error number
   input  wire logic [`ECI_HOLD_W-1:0] WARN_HOLD_MS,     // protocol warning hold time
   input  wire logic                   CONFIG_MODE,      // unit is in configuration mode
   input  wire logic                   SCRIPT_RED,       // script status lamp red
   input  wire logic                   SCRIPT_GREEN,     // script status lamp green
   input  wire eci_pkg::eci_code_t     SCRIPT_CODE,      // script code lamp pattern
   output logic                        STATE_RED,        // status lamp red
   output logic                        STATE_GREEN,      // status lamp green
   output logic                        CODE_LAMP_BIT3,   // code lamp, weight 8
   output logic                        CODE_LAMP_BIT2,   // code lamp, weight 4
   output logic                        CODE_LAMP_BIT1,   // code lamp, weight 2
   output logic                        CODE_LAMP_BIT0,   // code lamp, weight 1
   output logic                        DISPLAY_VALID,    // lamps carry an error number
   output logic                        ERR_SERIOUS,      // a serious error is latched
   output logic                        ERR_DROPPED,      // pulse: report not displayed
   output logic [`ECI_COUNT_W-1:0]     ERR_COUNT         // accepted reports, saturating
);
   import eci_pkg::*;

   if (CYC_PER_MS < 1) begin : g_chk
      $error("eci_top: CYC_PER_MS must be at least 1");
   end

   localparam logic [`ECI_HOLD_W-1:0] SYS_HOLD_MS =
      `ECI_HOLD_W'(`ECI_WARN_HOLD_MIN * `ECI_MS_PER_MIN);

   // a code is shown only if its table defines it; reserved codes are dropped
   function automatic logic code_defined(input eci_set_e set, input eci_code_t code);
      logic [15:0] mask;
      mask = (set == ECI_SET_PROT) ? `ECI_PROT_VALID_MASK   // [RQ9]
                                   : `ECI_SYS_VALID_MASK;   // [RQ5] [RQ6]
      return mask[code];
   endfunction

   function automatic logic code_serious(input eci_code_t code);
      return (code != 4'h0) && (code <= `ECI_SERIOUS_MAX);
   endfunction

   eci_tick_if tk ();

   eci_tick #(
      .CYC_PER_MS (CYC_PER_MS)
   ) u_tick (
      .clk     (CLK_SYS),
      .reset_n (RESET_N),
      .tk      (tk.src)
   );

   logic                   hold_load;
   logic [`ECI_HOLD_W-1:0] hold_ms;
   logic                   hold_expired;

   eci_hold u_hold (
      .clk     (CLK_SYS),
      .reset_n (RESET_N),
      .tk      (tk.snk),
      .load    (hold_load),
      .load_ms (hold_ms),
      .expired (hold_expired)
   );

   // ---- error state group
   eci_state_e               st_q, st_d;
   eci_code_t                code_q, code_d;
   eci_set_e                 set_q, set_d;
   logic                     drop_q, drop_d;
   logic [`ECI_COUNT_W-1:0]  cnt_q, cnt_d;
   logic                     accept;
   logic                     new_serious;

   assign accept      = ERR_VALID && code_defined(ERR_SET, ERR_CODE);
   assign new_serious = code_serious(ERR_CODE);

   // serious state is absorbing: only reset leaves it, and a new report wins
   // over an expiry in the same cycle so no report is ever lost silently
   always_comb begin
      st_d      = st_q;
      code_d    = code_q;
      set_d     = set_q;
      drop_d    = 1'b0;
      cnt_d     = cnt_q;
      hold_load = 1'b0;
      hold_ms   = (ERR_SET == ECI_SET_PROT) ? WARN_HOLD_MS : SYS_HOLD_MS;  // [RQ3] [RQ10]
      case (st_q)
         ECI_ST_IDLE: begin
            if (accept) begin
               code_d = ERR_CODE;                                     // [RQ1]
               set_d  = ERR_SET;
               if (new_serious) begin
                  st_d = ECI_ST_SERIOUS;                              // [RQ2]
               end else begin
                  st_d      = ECI_ST_WARN;
                  hold_load = 1'b1;                                   // [RQ3]
               end
            end
         end
         ECI_ST_WARN: begin
            if (accept) begin
               code_d = ERR_CODE;
               set_d  = ERR_SET;
               if (new_serious) begin
                  st_d = ECI_ST_SERIOUS;                              // [RQ13]
               end else begin
                  hold_load = 1'b1;                                   // newest warning restarts
               end
            end else if (hold_expired) begin
               st_d = ECI_ST_IDLE;                                    // [RQ3] [RQ10]
            end
         end
         ECI_ST_SERIOUS: begin
            st_d = ECI_ST_SERIOUS;                                    // [RQ2] [RQ13]
         end
         default: begin
            st_d = ECI_ST_IDLE;
         end
      endcase
      // reports that change nothing on the lamps are flagged to the caller
      if (ERR_VALID && (!accept || (st_q == ECI_ST_SERIOUS))) begin
         drop_d = 1'b1;
      end
      if (accept && (st_q != ECI_ST_SERIOUS) && (cnt_q != '1)) begin   // refused while serious
         cnt_d = cnt_q + `ECI_COUNT_W'(1);
      end
   end

   always_ff @(posedge CLK_SYS or negedge RESET_N) begin
      if (!RESET_N) begin
         st_q   <= ECI_ST_IDLE;
         code_q <= 4'h0;
         set_q  <= ECI_SET_SYS;
         drop_q <= 1'b0;
         cnt_q  <= '0;
      end else begin
         st_q   <= st_d;
         code_q <= code_d;
         set_q  <= set_d;
         drop_q <= drop_d;
         cnt_q  <= cnt_d;
      end
   end

   // ---- lamp drive group
   logic       red_q, red_d;
   logic       green_q, green_d;
   eci_code_t  lamp_q, lamp_d;
   logic       valid_q, valid_d;
   logic       serious_q, serious_d;
   logic       showing;
   logic       flash_on;

   assign showing  = (st_q != ECI_ST_IDLE) && !CONFIG_MODE;              // [RQ4]
   assign flash_on = (set_q == ECI_SET_PROT) ? tk.prot_on : tk.sys_on;   // [RQ7] [RQ8]

   // error display pre-empts the script; config mode hands lamps back to it,
   // since an error pattern there would be misread
   always_comb begin
      serious_d = (st_q == ECI_ST_SERIOUS);
      if (showing) begin
         red_d   = 1'b1;                                              // [RQ1] [RQ11]
         green_d = 1'b0;
         lamp_d  = flash_on ? code_q : 4'h0;                          // [RQ1] [RQ11]
         valid_d = 1'b1;                                              // [RQ11]
      end else begin
         red_d   = SCRIPT_RED;                                        // [RQ12]
         green_d = SCRIPT_GREEN;
         lamp_d  = SCRIPT_CODE;                                       // [RQ12]
         valid_d = 1'b0;                                              // [RQ4] [RQ11]
      end
   end

   always_ff @(posedge CLK_SYS or negedge RESET_N) begin
      if (!RESET_N) begin
         red_q     <= 1'b0;
         green_q   <= 1'b0;
         lamp_q    <= 4'h0;
         valid_q   <= 1'b0;
         serious_q <= 1'b0;
      end else begin
         red_q     <= red_d;
         green_q   <= green_d;
         lamp_q    <= lamp_d;
         valid_q   <= valid_d;
         serious_q <= serious_d;
      end
   end

   // every output straight from a flip-flop
   assign STATE_RED      = red_q;
   assign STATE_GREEN    = green_q;
   assign CODE_LAMP_BIT3 = lamp_q[3];
   assign CODE_LAMP_BIT2 = lamp_q[2];
   assign CODE_LAMP_BIT1 = lamp_q[1];
   assign CODE_LAMP_BIT0 = lamp_q[0];
   assign DISPLAY_VALID  = valid_q;
   assign ERR_SERIOUS    = serious_q;
   assign ERR_DROPPED    = drop_q;
   assign ERR_COUNT      = cnt_q;

endmodule // eci_top

// >>> verif/eci_top_assertions.sv
`timescale 1ns/1ps
`include "eci_map.svh"
module eci_chk #(
   parameter int CYC_PER_MS = 2
) (
   input wire logic                    CLK_SYS,        // system clock
   input wire logic                    RESET_N,        // async reset, active low
   input wire logic                    ERR_VALID,      // report strobe
   input wire eci_pkg::eci_set_e       ERR_SET,        // code table
   input wire eci_pkg::eci_code_t      ERR_CODE,       // reported number
   input wire logic                    CONFIG_MODE,    // configuration mode
   input wire logic                    SCRIPT_RED,     // script red
   input wire logic                    SCRIPT_GREEN,   // script green
   input wire eci_pkg::eci_code_t      SCRIPT_CODE,    // script pattern
   input wire logic                    STATE_RED,      // status lamp red
   input wire logic                    STATE_GREEN,    // status lamp green
   input wire logic                    CODE_LAMP_BIT3, // weight 8
   input wire logic                    CODE_LAMP_BIT2, // weight 4
   input wire logic                    CODE_LAMP_BIT1, // weight 2
   input wire logic                    CODE_LAMP_BIT0, // weight 1
   input wire logic                    DISPLAY_VALID,  // lamps carry a number
   input wire logic                    ERR_SERIOUS,    // serious latched
   input wire logic                    ERR_DROPPED,    // report refused
   input wire logic [`ECI_COUNT_W-1:0] ERR_COUNT       // accepted reports
);
   import eci_pkg::*;
   logic [15:0] ok_map;
   logic        defined;
   logic [3:0]  lamps;
   logic        blocked_q;   // a serious code was taken, later reports are refused
   // defined codes of each table, written out from the code lists
   assign ok_map  = (ERR_SET == ECI_SET_PROT) ? 16'hDA28 : 16'h6FBE;
   assign defined = ok_map[ERR_CODE];
   assign lamps   = {CODE_LAMP_BIT3, CODE_LAMP_BIT2, CODE_LAMP_BIT1, CODE_LAMP_BIT0};

   // serious state rebuilt from the reports; the flag output lags it by one cycle,
   // so a report right after a serious one must already count as refused
   always_ff @(posedge CLK_SYS or negedge RESET_N) begin
      if (!RESET_N) begin
         blocked_q <= 1'b0;
      end else if (ERR_VALID && defined && (ERR_CODE inside {[4'h1:4'h5]})) begin
         blocked_q <= 1'b1;
      end
   end

   default clocking cb @(posedge CLK_SYS); endclocking
   default disable iff (!RESET_N);

   sequence take_err;
      ERR_VALID && defined && !blocked_q;
   endsequence
   sequence take_serious;
      take_err ##0 (ERR_CODE inside {[4'h1:4'h5]});
   endsequence

   red_on_error_a: assert property (take_err ##1 !CONFIG_MODE
      |=> STATE_RED && DISPLAY_VALID)
      else $error("status lamp not red after an error");
   serious_latch_a: assert property (take_serious |=> ##1 ERR_SERIOUS)
      else $error("serious code not latched");
   serious_flag_a: assert property (ERR_SERIOUS == $past(blocked_q))
      else $error("serious flag does not match the reports");
   serious_stays_a: assert property (ERR_SERIOUS && !CONFIG_MODE
      |=> ERR_SERIOUS && DISPLAY_VALID)
      else $error("serious display went away");
   drop_undef_a: assert property (ERR_VALID && (!defined || blocked_q)
      |=> ERR_DROPPED && $stable(ERR_COUNT))
      else $error("reserved or blocked code not refused");
   count_step_a: assert property (take_err ##0 ERR_COUNT != 8'hFF
      |=> ERR_COUNT == $past(ERR_COUNT) + 8'h01)
      else $error("accepted report not counted");
   config_blank_a: assert property (CONFIG_MODE
      |=> !DISPLAY_VALID && lamps == $past(SCRIPT_CODE))
      else $error("config mode still shows an error");
   script_idle_a: assert property (!DISPLAY_VALID && $past(RESET_N)
      |-> lamps == $past(SCRIPT_CODE) && STATE_RED == $past(SCRIPT_RED))
      else $error("idle lamps do not follow script");
   valid_red_a: assert property (DISPLAY_VALID |-> STATE_RED && !STATE_GREEN)
      else $error("error number shown without red lamp");
endmodule // eci_chk

bind eci_top eci_chk #(.CYC_PER_MS(CYC_PER_MS)) u_chk (.CLK_SYS(CLK_SYS), .RESET_N(RESET_N),
   .ERR_VALID(ERR_VALID), .ERR_SET(ERR_SET), .ERR_CODE(ERR_CODE), .CONFIG_MODE(CONFIG_MODE),
   .SCRIPT_RED(SCRIPT_RED), .SCRIPT_GREEN(SCRIPT_GREEN), .SCRIPT_CODE(SCRIPT_CODE),
   .STATE_RED(STATE_RED), .STATE_GREEN(STATE_GREEN), .CODE_LAMP_BIT3(CODE_LAMP_BIT3),
   .CODE_LAMP_BIT2(CODE_LAMP_BIT2), .CODE_LAMP_BIT1(CODE_LAMP_BIT1),
   .CODE_LAMP_BIT0(CODE_LAMP_BIT0), .DISPLAY_VALID(DISPLAY_VALID), .ERR_SERIOUS(ERR_SERIOUS),
   .ERR_DROPPED(ERR_DROPPED), .ERR_COUNT(ERR_COUNT));

// >>> verif/eci_lamp_model.sv
`timescale 1ns/1ps
// reads the code lamps as an operator would: counts flashes, notes the lit code
module eci_lamp_model (
   input  wire logic       clk,       // system clock
   input  wire logic       reset_n,   // async reset, active low
   input  wire logic       clr,       // restart the flash count
   input  wire logic [3:0] lamps,     // code lamps, bit3 weight 8
   output logic      [7:0] flash_cnt, // dark-to-lit changes seen
   output logic      [3:0] last_lit   // pattern while lit
);
   logic       lit_q, lit_d;
   logic [7:0] cnt_q, cnt_d;
   logic [3:0] code_q, code_d;
   // only a lit pattern is a code; the dark phase carries nothing
   always_comb begin
      lit_d  = |lamps;
      cnt_d  = clr ? 8'h00 : cnt_q + 8'(lit_d && !lit_q);
      code_d = lit_d ? lamps : code_q;
   end
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         lit_q  <= 1'b0;
         cnt_q  <= 8'h00;
         code_q <= 4'h0;
      end else begin
         lit_q  <= lit_d;
         cnt_q  <= cnt_d;
         code_q <= code_d;
      end
   end
   assign flash_cnt = cnt_q;
   assign last_lit  = code_q;
endmodule // eci_lamp_model

// >>> verif/eci_tb.sv
`timescale 1ns/1ps
module testbench;
   import eci_pkg::*;
   localparam int CP     = 1;          // one-cycle ms tick keeps the minute hold in budget
   localparam int FRAME  = 1000 * CP;  // one second in cycles
   localparam int MINUTE = 60000 * CP; // fixed system warning hold in cycles
   logic        clk = 1'b0, rst_n = 1'b0, err_valid = 1'b0, cfg = 1'b0, clr = 1'b0;
   logic        s_red = 1'b0, s_green = 1'b0;
   eci_set_e    err_set = ECI_SET_SYS;
   eci_code_t   err_code = 4'h0, s_code = 4'h0;
   logic [19:0] hold = 20'h00000;
   logic        red, green, valid, serious, dropped;
   wire  [3:0]  lamps;               // one port driver per lamp bit
   logic [3:0]  seen;
   logic [7:0]  count, flashes;
   int          n_errors = 0, total_checks = 0, cycles = 0;

   eci_top #(.CYC_PER_MS(CP)) i_dut (.CLK_SYS(clk), .RESET_N(rst_n), .ERR_VALID(err_valid),
      .ERR_SET(err_set), .ERR_CODE(err_code), .WARN_HOLD_MS(hold), .CONFIG_MODE(cfg),
      .SCRIPT_RED(s_red), .SCRIPT_GREEN(s_green), .SCRIPT_CODE(s_code), .STATE_RED(red),
      .STATE_GREEN(green), .CODE_LAMP_BIT3(lamps[3]), .CODE_LAMP_BIT2(lamps[2]),
      .CODE_LAMP_BIT1(lamps[1]), .CODE_LAMP_BIT0(lamps[0]), .DISPLAY_VALID(valid),
      .ERR_SERIOUS(serious), .ERR_DROPPED(dropped), .ERR_COUNT(count));
   eci_lamp_model i_lamps (.clk(clk), .reset_n(rst_n), .clr(clr), .lamps(lamps),
      .flash_cnt(flashes), .last_lit(seen));

   initial forever #2.5 clk = ~clk;
   // a hang is cut short well after the longest expected run
   always @(posedge clk) begin
      cycles++;
      if (cycles == 80000) begin
         n_errors++;
         $display("ERROR at %0t: run did not finish", $time);
         report_and_stop();
      end
   end

   task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
      total_checks++;
      if (got !== exp) begin
         n_errors++;
         $display("ERROR at %0t: %s got %0h expected %0h", $time, what, got, exp);
      end
   endtask
   task automatic do_reset();
      @(posedge clk) rst_n <= 1'b0;
      repeat (3) @(posedge clk);
      rst_n <= 1'b1;
   endtask
   task automatic wait_cyc(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask
   // one-cycle report; returns just after the edge that takes it
   task automatic report(input eci_set_e s, input eci_code_t c, input logic [19:0] h);
      @(posedge clk);
      err_valid <= 1'b1;
      err_set   <= s;
      err_code  <= c;
      hold      <= h;
      @(posedge clk) err_valid <= 1'b0;
      #1;
   endtask
   // counts exactly one second of edges, so the rise count is exact
   task automatic flash_check(input logic [7:0] n, input eci_code_t c);
      @(posedge clk) clr <= 1'b1;
      @(posedge clk) clr <= 1'b0;
      wait_cyc(FRAME);
      chk(flashes, n, "flashes per second");
      chk(8'(seen), 8'(c), "lamp code");
   endtask

   task automatic test_serious();
      do_reset();
      report(ECI_SET_SYS, 4'h5, 20'h00001);
      wait_cyc(2);
      chk(8'({red, green, valid, serious}), 8'h0B, "serious shown");
      chk(count, 8'h01, "accepted count");
      flash_check(8'h02, 4'h5);
      report(ECI_SET_SYS, 4'h7, 20'h00001);
      chk(8'(dropped), 8'h01, "warning over serious");
      chk(count, 8'h01, "refused report not counted");
      flash_check(8'h02, 4'h5);
      $display("test serious done");
   endtask

   // a system warning keeps the fixed minute whatever the hold input says
   task automatic test_sys_warning();
      do_reset();
      report(ECI_SET_SYS, 4'h8, 20'h00001);
      wait_cyc(2);
      chk(8'({red, valid, serious}), 8'h06, "system warning shown");
      flash_check(8'h02, 4'h8);
      wait_cyc(MINUTE - FRAME - 24);
      chk(8'(valid), 8'h01, "minute hold running");
      wait_cyc(30);
      chk(8'({valid, red, lamps}), 8'h00, "system warning cleared alone");
      $display("test system warning done");
   endtask

   task automatic test_protocol();
      do_reset();
      report(ECI_SET_PROT, 4'hC, 20'h005DC);
      wait_cyc(2);
      chk(8'({red, valid, serious}), 8'h06, "protocol warning shown");
      flash_check(8'h01, 4'hC);
      report(ECI_SET_PROT, 4'h9, 20'h00003);
      wait_cyc(4);
      chk(8'(valid), 8'h01, "short hold running");
      wait_cyc(10);
      chk(8'({valid, red, lamps}), 8'h00, "warning cleared alone");
      $display("test protocol done");
   endtask

   task automatic test_codes();
      logic [15:0] ok;
      logic [7:0]  n;
      do_reset();
      n = 8'h00;
      for (int s = 0; s < 2; s++) begin
         ok = (s == 1) ? 16'hDA28 : 16'h6FBE;
         for (int c = 15; c >= 0; c--) begin
            if (ok[c] && c >= 1 && c <= 5) continue;
            report(eci_set_e'(s), 4'(c), 20'h005DC);
            n = n + 8'(ok[c]);
            chk(8'(dropped), 8'(!ok[c]), "reserved code refused");
            chk(count, n, "accepted count");
         end
      end
      @(posedge clk);
      cfg     <= 1'b1;
      s_code  <= 4'hA;
      s_green <= 1'b1;
      wait_cyc(2);
      chk(8'({valid, green, lamps}), 8'h1A, "config shows script");
      @(posedge clk) cfg <= 1'b0;
      wait_cyc(2);
      chk(8'({valid, red, green}), 8'h06, "error back after config");
      $display("test codes done");
   endtask

   initial begin
      test_serious();
      test_sys_warning();
      test_protocol();
      test_codes();
      report_and_stop();
   end

   task automatic report_and_stop();
      $display("checks %0d, mismatches %0d", total_checks, n_errors);
      if (n_errors == 0 && total_checks > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask
endmodule // testbench
